// ==== srf_pkg.sv ====
// constants, field layouts and types for the sensor result fifo
// assumes a single core clock domain and an apb register port
package srf_pkg;

  // ----------------------------------------------------------------
  // storage geometry
  // ----------------------------------------------------------------
  localparam int unsigned DEPTH = 512;
  localparam logic [4:0] MAX_FRAME = 5'h09;
  localparam logic [3:0] SAMPLE_BYTES = 4'h3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNTLO = 8'h04;
  localparam logic [7:0] OFS_CNTHI = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_BURST = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [2:0] IDX_DATA = 3'h5;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_OVF = 0;
  localparam int STAT_FLUSH = 1;
  localparam int STAT_BUSY = 2;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [2:0] PTR_RST = 3'h5;

  // ----------------------------------------------------------------
  // frame header coding
  // ----------------------------------------------------------------
  localparam logic [1:0] TYPE_SENSOR = 2'h2;
  localparam logic [1:0] TYPE_CTRL = 2'h1;
  localparam logic [3:0] PARAM_CFGERR = 4'h1;
  localparam logic [3:0] PARAM_CFGCHG = 4'h2;
  localparam logic [1:0] SEL_FILTERED = 2'h1;
  localparam logic [7:0] HDR_EMPTY = 8'h80;
  localparam logic [7:0] HDR_TIME = 8'hA0;
  localparam int HDR_TEMP = 4;
  localparam int HDR_PRESS = 2;

  // control register layout, bit 9 downward
  typedef struct packed {
    logic [2:0] subsamp;
    logic [1:0] srcSel;
    logic stopOnFull;
    logic timeEn;
    logic tempEn;
    logic pressEn;
    logic collect;
  } srf_ctrl_t;

  // one pressure and one temperature result
  typedef struct packed {
    logic [23:0] temp;
    logic [23:0] press;
  } srf_meas_t;

  typedef enum logic [1:0] {WR_IDLE, WR_ROOM, WR_BYTES} srf_wstate_t;

  // stored frame length from its header; control frames are header only
  function automatic logic [3:0] frameLen(input logic [7:0] hdr);
    logic [3:0] len;
    len = 4'h1;
    if (hdr[7:6] == TYPE_SENSOR && hdr[HDR_TEMP]) len = len + SAMPLE_BYTES;
    if (hdr[7:6] == TYPE_SENSOR && hdr[HDR_PRESS]) len = len + SAMPLE_BYTES;
    return len;
  endfunction

endpackage

// ==== srf_fifo.sv ====
// byte-wide result fifo with apb register port and frame framing
// assumes the measurement engine pulses measDone with stable results
// Notes on behaviour
// - store holds 512 bytes of frames
// - no writing unless collect and a channel enabled
// - disabled store stays readable and flushable
// - each channel stored only when its enable set
// - source select 01 picks filtered results
// - nine-bit count split low byte, high bit
// - count moves only on whole frames
// - count steps by whole frame length
// - keep one of two-to-the-n samples
// - subsample only in normal mode, on grid
// - sleep-to-normal resets subsample counter
// - data register reads block writing only while a streaming drop waits on them
// - burst pointer stops at data register
// - full means free space below nine
// - streaming drops oldest frames until fit
// - stop-on-full drops incoming frame
// - header holds type and parameter fields
// - type codes for sensor and control frames
// - sensor header bit layout fixed
// - flag combinations select frame kind
// - time frame carries three time bytes
// - time frame appended after stored data
//
// Chosen here: the register addresses and the APB register port.
module srf_fifo #(
  parameter int unsigned DEPTH = srf_pkg::DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement engine
  input wire logic measDone,
  input wire logic modeNormal,
  input wire srf_pkg::srf_meas_t measRaw,
  input wire srf_pkg::srf_meas_t measFilt,
  input wire logic cfgError,
  input wire logic [23:0] sensorTime
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_badDepth
    $error("srf_fifo: DEPTH must be a power of two of at least 256");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  srf_pkg::srf_ctrl_t ctrl_r;
  srf_pkg::srf_wstate_t ws_r;
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] cnt_r, head_r, wrPtr_r;
  logic [3:0] rdOff_r, wlen_r, widx_r;
  logic [55:0] frm_r;
  logic ovf_r, srcFifo_r, timeSent_r, normPrev_r;
  logic [1:0] tIdx_r, ctlPend_r;
  logic [2:0] ptr_r;
  logic [6:0] ds_r;
  logic [23:0] timeCap_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup, acc, wrAcc, isData, mapped, flush, ctrlWr, cfgChg;
  logic [7:0] effAddr;
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wrAcc = acc & pwrite;
  // burst window reads whichever register the pointer names
  assign effAddr = (paddr == srf_pkg::OFS_BURST) ? {3'h0, ptr_r, 2'h0} : paddr;
  assign isData = ~pwrite & (effAddr == srf_pkg::OFS_DATA);
  assign mapped = paddr inside {srf_pkg::OFS_CTRL, srf_pkg::OFS_CNTLO, srf_pkg::OFS_CNTHI,
                                srf_pkg::OFS_STAT, srf_pkg::OFS_BURST, srf_pkg::OFS_DATA};
  assign ctrlWr = wrAcc & (paddr == srf_pkg::OFS_CTRL);
  assign flush = wrAcc & (paddr == srf_pkg::OFS_STAT) & pwdata[srf_pkg::STAT_FLUSH];
  // channel or source change while collecting emits a control frame
  assign cfgChg = ctrlWr & pwdata[0] & (pwdata[6:1] != {ctrl_r.srcSel, ctrl_r.stopOnFull,
                  ctrl_r.timeEn, ctrl_r.tempEn, ctrl_r.pressEn});

  // ----------------------------------------------------------------
  // fifo head and read side
  // ----------------------------------------------------------------
  logic [7:0] hdHdr, curByte;
  logic [3:0] hdLen;
  logic [AW:0] freeSp;
  logic fits, popFifo, popTime, frmDone, dropNow, commit, wrOn, keep;
  assign hdHdr = mem[head_r];
  assign hdLen = srf_pkg::frameLen(hdHdr);
  assign curByte = mem[head_r + AW'(rdOff_r)];
  assign freeSp = (AW+1)'(DEPTH) - {1'b0, cnt_r};
  assign fits = freeSp >= (AW+1)'(srf_pkg::MAX_FRAME);
  assign popFifo = acc & isData & srcFifo_r;
  assign popTime = acc & isData & ~srcFifo_r & ctrl_r.timeEn & ~timeSent_r;
  assign frmDone = popFifo & (rdOff_r + 4'h1 == hdLen);
  // drop only at a frame boundary and never under a pending data read
  assign dropNow = (ws_r == srf_pkg::WR_ROOM) & ~fits & ~ctrl_r.stopOnFull & (rdOff_r == 4'h0)
                   & ~(psel & isData);
  assign commit = (ws_r == srf_pkg::WR_BYTES) & (widx_r == wlen_r - 4'h1);
  assign wrOn = ctrl_r.collect & (ctrl_r.pressEn | ctrl_r.tempEn);
  // subsampling only in normal mode; other modes keep every result
  assign keep = measDone & (~modeNormal | ~normPrev_r | (ds_r == 7'h00));

  // read value for the setup cycle
  logic [31:0] rdVal;
  always_comb begin
    rdVal = 32'h0000_0000;
    unique case (effAddr)
      srf_pkg::OFS_CTRL: rdVal = 32'(ctrl_r);
      srf_pkg::OFS_CNTLO: rdVal = 32'(cnt_r[7:0]);
      srf_pkg::OFS_CNTHI: rdVal = 32'(cnt_r[AW-1:8]);
      srf_pkg::OFS_STAT: rdVal = 32'({ws_r != srf_pkg::WR_IDLE, 1'b0, ovf_r});
      srf_pkg::OFS_DATA: begin
        if (cnt_r != '0) begin
          rdVal = 32'(curByte);
        end else if (ctrl_r.timeEn && !timeSent_r) begin
          unique case (tIdx_r)
            2'h0: rdVal = 32'(srf_pkg::HDR_TIME);
            2'h1: rdVal = 32'(timeCap_r[7:0]);
            2'h2: rdVal = 32'(timeCap_r[15:8]);
            2'h3: rdVal = 32'(timeCap_r[23:16]);
          endcase
        end else begin
          rdVal = 32'(srf_pkg::HDR_EMPTY);
        end
      end
      default: rdVal = 32'h0000_0000;
    endcase
  end

  // apb answer: one wait-free access phase, data latched at setup
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      srcFifo_r <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & mapped & ~pwrite) ? rdVal : 32'h0000_0000;
      if (setup) srcFifo_r <= (cnt_r != '0);
    end
  end

  // control register; flush lives elsewhere so settings survive it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_r <= srf_pkg::CTRL_RST;
    end else if (ctrlWr) begin
      ctrl_r <= pwdata[9:0];
    end
  end

  // burst pointer parks on the data register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptr_r <= srf_pkg::PTR_RST;
    end else if (wrAcc && paddr == srf_pkg::OFS_BURST) begin
      ptr_r <= (pwdata[2:0] > srf_pkg::IDX_DATA) ? srf_pkg::IDX_DATA : pwdata[2:0];
    end else if (acc && !pwrite && paddr == srf_pkg::OFS_BURST && ptr_r != srf_pkg::IDX_DATA) begin
      ptr_r <= ptr_r + 3'h1;
    end
  end

  // overflow flag: hardware set wins over the clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ovf_r <= 1'b0;
    end else if (ws_r == srf_pkg::WR_ROOM && !fits) begin
      ovf_r <= 1'b1;
    end else if (wrAcc && paddr == srf_pkg::OFS_STAT && pwdata[srf_pkg::STAT_OVF]) begin
      ovf_r <= 1'b0;
    end
  end

  // byte count and head move by whole frames only
  logic [3:0] dec;
  assign dec = (frmDone | dropNow) ? hdLen : 4'h0;
  always_ff @(posedge core_clk) begin
    if (srst || flush) begin
      cnt_r <= '0;
      head_r <= '0;
      rdOff_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + AW'(commit ? wlen_r : 4'h0) - AW'(dec);
      head_r <= head_r + AW'(dec);
      if (frmDone) rdOff_r <= 4'h0;
      else if (popFifo) rdOff_r <= rdOff_r + 4'h1;
    end
  end

  // appended time frame, once per burst, sampled at its header
  always_ff @(posedge core_clk) begin
    if (srst || flush) begin
      tIdx_r <= 2'h0;
      timeSent_r <= 1'b0;
      timeCap_r <= 24'h00_0000;
    end else if (popTime) begin
      tIdx_r <= tIdx_r + 2'h1;
      if (tIdx_r == 2'h0) timeCap_r <= sensorTime;
      if (tIdx_r == 2'h3) timeSent_r <= 1'b1;
    end else if (acc && !isData) begin
      tIdx_r <= 2'h0; // any other access closes the burst
      timeSent_r <= 1'b0;
    end
  end

  // subsample counter on the measurement grid
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ds_r <= 7'h00;
      normPrev_r <= 1'b0;
    end else begin
      normPrev_r <= modeNormal;
      if (modeNormal && !normPrev_r) begin
        ds_r <= 7'h00;
      end else if (measDone && modeNormal) begin
        ds_r <= (ds_r + 7'h01) & 7'((8'h01 << ctrl_r.subsamp) - 8'h01);
      end
    end
  end

  // control frame requests; a new event wins over its clear
  logic takeErr, takeChg;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctlPend_r <= 2'h0;
    end else begin
      ctlPend_r[0] <= cfgError | (ctlPend_r[0] & ~takeErr);
      ctlPend_r[1] <= cfgChg | (ctlPend_r[1] & ~takeChg);
    end
  end

  // frame image built from the enabled channels, lsb first
  srf_pkg::srf_meas_t src;
  logic [7:0] hdr;
  logic [55:0] measFrm;
  logic [3:0] measLen;
  always_comb begin
    src = (ctrl_r.srcSel == srf_pkg::SEL_FILTERED) ? measFilt : measRaw;
    hdr = {srf_pkg::TYPE_SENSOR, 1'b0, ctrl_r.tempEn, 1'b0, ctrl_r.pressEn, 2'h0};
    measFrm = {24'h0, src.press, hdr};
    measLen = 4'h1 + srf_pkg::SAMPLE_BYTES;
    if (ctrl_r.tempEn && !ctrl_r.pressEn) begin
      measFrm = {24'h0, src.temp, hdr};
    end else if (ctrl_r.tempEn && ctrl_r.pressEn) begin
      measFrm = {src.temp, src.press, hdr};
      measLen = 4'h1 + srf_pkg::SAMPLE_BYTES + srf_pkg::SAMPLE_BYTES;
    end
  end

  logic idleFree;
  assign idleFree = (ws_r == srf_pkg::WR_IDLE) & ~flush & wrOn;
  assign takeErr = idleFree & ~keep & ctlPend_r[0];
  assign takeChg = idleFree & ~keep & ~ctlPend_r[0] & ctlPend_r[1];

  // frame writer: load, make room, copy bytes, commit
  always_ff @(posedge core_clk) begin
    if (srst || flush) begin
      ws_r <= srf_pkg::WR_IDLE;
      frm_r <= 56'h0;
      wlen_r <= 4'h0;
      widx_r <= 4'h0;
      wrPtr_r <= '0;
    end else begin
      unique case (ws_r)
        srf_pkg::WR_IDLE: begin
          widx_r <= 4'h0;
          if (idleFree && keep) begin
            frm_r <= measFrm;
            wlen_r <= measLen;
            ws_r <= srf_pkg::WR_ROOM;
          end else if (takeErr || takeChg) begin
            frm_r <= {48'h0, srf_pkg::TYPE_CTRL,
                      takeErr ? srf_pkg::PARAM_CFGERR : srf_pkg::PARAM_CFGCHG, 2'h0};
            wlen_r <= 4'h1;
            ws_r <= srf_pkg::WR_ROOM;
          end
        end
        srf_pkg::WR_ROOM: begin
          if (fits) ws_r <= srf_pkg::WR_BYTES;
          else if (ctrl_r.stopOnFull) ws_r <= srf_pkg::WR_IDLE;
        end
        srf_pkg::WR_BYTES: begin
          frm_r <= frm_r >> 8;
          widx_r <= widx_r + 4'h1;
          wrPtr_r <= wrPtr_r + AW'(1);
          if (commit) ws_r <= srf_pkg::WR_IDLE;
        end
        default: ws_r <= srf_pkg::WR_IDLE;
      endcase
    end
  end

  // storage array, written one byte per cycle ahead of the count
  always_ff @(posedge core_clk) begin
    if (ws_r == srf_pkg::WR_BYTES && !flush) mem[wrPtr_r] <= frm_r[7:0];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  stopOnFull_a: assert property ((ws_r == srf_pkg::WR_ROOM && !fits && ctrl_r.stopOnFull && !flush)
    |=> (ws_r == srf_pkg::WR_IDLE && ovf_r)) else $error("full frame not dropped");
  streamDrop_a: assert property ((dropNow && !flush) |=> head_r == $past(head_r) + AW'($past(hdLen)))
    else $error("oldest frame not released");
  countStep_a: assert property ((cnt_r != $past(cnt_r))
    |-> ($past(commit) || $past(frmDone) || $past(dropNow) || $past(flush) || $past(srst)))
    else $error("count moved mid frame");
  noWrite_a: assert property ((ws_r == srf_pkg::WR_IDLE && !wrOn) |=> ws_r == srf_pkg::WR_IDLE)
    else $error("writer started while disabled");
  srcSel_a: assert property ((idleFree && keep && ctrl_r.pressEn && !ctrl_r.tempEn)
    |=> frm_r[31:8] == ($past(ctrl_r.srcSel) == srf_pkg::SEL_FILTERED
      ? $past(measFilt.press) : $past(measRaw.press)))
    else $error("wrong result source");
  hdrShape_a: assert property ((idleFree && keep) |=> (frm_r[7:6] == srf_pkg::TYPE_SENSOR
    && !frm_r[5] && !frm_r[3] && frm_r[1:0] == 2'h0)) else $error("bad sensor header");
  flushZero_a: assert property (flush |=> (cnt_r == '0 && ctrl_r == $past(ctrl_r)))
    else $error("flush left data or changed settings");
  burstStop_a: assert property ((acc && !pwrite && paddr == srf_pkg::OFS_BURST
    && ptr_r == srf_pkg::IDX_DATA) |=> ptr_r == srf_pkg::IDX_DATA) else $error("burst pointer ran past data");
  emptyHdr_a: assert property ((setup && isData && cnt_r == '0 && (timeSent_r || !ctrl_r.timeEn))
    |=> prdata == 32'(srf_pkg::HDR_EMPTY)) else $error("no empty frame after drain");
  timeHdr_a: assert property ((setup && isData && cnt_r == '0 && ctrl_r.timeEn && !timeSent_r
    && tIdx_r == 2'h0) |=> prdata == 32'(srf_pkg::HDR_TIME)) else $error("time frame not appended");
  fullGate_a: assert property ((ws_r == srf_pkg::WR_ROOM && !fits) |=> ws_r != srf_pkg::WR_BYTES)
    else $error("write began without room");

  commitSeen_c: cover property (commit);
  streamDrop_c: cover property (dropNow);
  fullStop_c: cover property (ws_r == srf_pkg::WR_ROOM && !fits && ctrl_r.stopOnFull);
  timeFrame_c: cover property (popTime && tIdx_r == 2'h3);

endmodule // srf_fifo

// ==== srf_engine_model.sv ====
// behavioural measurement engine feeding the result fifo
// assumes go and fault are one-cycle bench pulses spaced ten cycles or more
module srf_engine_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bench control
  input wire logic go,
  input wire logic fault,
  input wire logic [23:0] seed,
  // fifo side
  output logic measDone,
  output srf_pkg::srf_meas_t measRaw,
  output srf_pkg::srf_meas_t measFilt,
  output logic cfgError,
  output logic [23:0] sensorTime
);
  timeunit 1ns;
  timeprecision 1ps;
  // results move only with a new pulse, so they stand with measDone
  always_ff @(posedge core_clk) begin
    measDone <= go & ~srst;
    cfgError <= fault & ~srst;
    if (srst) begin
      measRaw <= '0;
      measFilt <= '0;
      sensorTime <= 24'h0;
    end else if (go) begin
      measRaw <= {~seed, seed};
      measFilt <= {~seed ^ 24'hA5A5A5, seed ^ 24'h5A5A5A};
      sensorTime <= seed ^ 24'h3C3C3C; // time held still so its sampling moment is moot
    end
  end
endmodule // srf_engine_model

// ==== sensor_result_fifo_tb.sv ====
// self-checking bench for the sensor result fifo over apb
// assumes the engine model beside it and a wait-free apb slave
module sensor_result_fifo_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, rs = 32'hFD3F;
  logic pready, pslverr, perr, measDone, modeNormal = 0, go = 0, fault = 0, cfgError;
  logic [23:0] seed = 24'h0, sensorTime, tm;
  logic [23:0] sd [80];
  logic [8:0] len;
  logic [3:0] cfg [5] = '{4'hA, 4'h5, 4'hE, 4'hF, 4'h1};
  srf_pkg::srf_meas_t measRaw, measFilt;
  int err_total = 0, tests_run = 0;
  // ----------------------------------------------------------------
  // clock, instances, helpers
  // ----------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  srf_fifo u_srf_fifo (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .measDone(measDone),
    .modeNormal(modeNormal), .measRaw(measRaw), .measFilt(measFilt), .cfgError(cfgError), .sensorTime(sensorTime));
  srf_engine_model u_srf_engine_model (.core_clk(core_clk), .srst(srst), .go(go), .fault(fault), .seed(seed),
    .measDone(measDone), .measRaw(measRaw), .measFilt(measFilt), .cfgError(cfgError), .sensorTime(sensorTime));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] mk(input logic p, t, ti, st, input logic [1:0] sel, input logic [2:0] sub);
    return {22'h0, sub, sel, st, ti, t, p, 1'b1};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; an idle edge first keeps strobes from being set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic cnt(input logic [8:0] e);
    rd(srf_pkg::OFS_CNTLO, {24'h0, e[7:0]});
    rd(srf_pkg::OFS_CNTHI, {31'h0, e[8]});
  endtask
  // settings with collect off, then collect, so that no configuration-change frame is emitted
  task automatic setc(input logic [31:0] v);
    apb(1'b1, srf_pkg::OFS_CTRL, v & 32'hFFFF_FFFE);
    apb(1'b1, srf_pkg::OFS_CTRL, v);
  endtask
  task automatic flush();
    apb(1'b1, srf_pkg::OFS_STAT, 32'h3);
  endtask
  task automatic meas(output logic [23:0] s, input logic mid, input logic [7:0] lo);
    rs = lfsr(rs);
    s = rs[23:0];
    @(posedge core_clk);
    seed <= s;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    if (mid) rd(srf_pkg::OFS_CNTLO, {24'h0, lo});
    repeat (12) @(posedge core_clk);
  endtask
  task automatic frame(input logic p, input logic t, input logic f, input logic [23:0] s);
    logic [23:0] pv, tv;
    pv = f ? s ^ 24'h5A5A5A : s;
    tv = f ? ~s ^ 24'hA5A5A5 : ~s;
    rd(srf_pkg::OFS_DATA, {24'h0, 2'h2, 1'b0, t, 1'b0, p, 2'h0});
    for (int i = 0; i < 3 && p; i++) rd(srf_pkg::OFS_DATA, {24'h0, pv[8*i +: 8]});
    for (int i = 0; i < 3 && t; i++) rd(srf_pkg::OFS_DATA, {24'h0, tv[8*i +: 8]});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(srf_pkg::OFS_CTRL, 32'h0);
    cnt(9'h0);
    rd(srf_pkg::OFS_DATA, 32'h80);
    apb(1'b1, 8'h40, 32'h1);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, srf_pkg::OFS_BURST, 32'h7);
    rd(srf_pkg::OFS_BURST, 32'h80);
    rd(srf_pkg::OFS_BURST, 32'h80);
    // channel enables and source select, the last entry has both channels off
    for (int k = 0; k < 5; k++) begin
      setc(mk(cfg[k][3], cfg[k][2], 1'b0, 1'b0, cfg[k][1:0], 3'h0));
      meas(sd[0], 1'b1, 8'h0);
      len = 9'h1 + (cfg[k][3] ? 9'h3 : 9'h0) + (cfg[k][2] ? 9'h3 : 9'h0);
      if (!cfg[k][3] && !cfg[k][2]) len = 9'h0;
      cnt(len);
      if (len != 9'h0) frame(cfg[k][3], cfg[k][2], cfg[k][1:0] == 2'h1, sd[0]);
      cnt(9'h0);
    end
    apb(1'b1, srf_pkg::OFS_CTRL, mk(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 3'h0));
    // the control frame needs a few cycles to be written and counted
    repeat (4) @(posedge core_clk);
    rd(srf_pkg::OFS_DATA, 32'h48);
    @(posedge core_clk);
    fault <= 1'b1;
    @(posedge core_clk);
    fault <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(srf_pkg::OFS_DATA, 32'h44);
    cnt(9'h0);
    // down-sampling by four in normal mode: first and fifth result kept
    setc(mk(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 3'h2));
    modeNormal <= 1'b1;
    for (int i = 0; i < 8; i++) meas(sd[i], 1'b0, 8'h0);
    cnt(9'h8);
    frame(1'b1, 1'b0, 1'b0, sd[0]);
    modeNormal <= 1'b0;
    flush();
    cnt(9'h0);
    // outside normal mode the subsample setting is ignored
    meas(tm, 1'b0, 8'h0);
    meas(tm, 1'b0, 8'h0);
    cnt(9'h8);
    flush();
    // stop-on-full: 72 frames of seven fill it, the 73rd is dropped
    setc(mk(1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 3'h0));
    for (int i = 0; i < 73; i++) meas(sd[i], 1'b0, 8'h0);
    cnt(9'h1F8);
    apb(1'b0, srf_pkg::OFS_STAT, 32'h0);
    chk({31'h0, q[srf_pkg::STAT_OVF]}, 32'h1);
    frame(1'b1, 1'b1, 1'b0, sd[0]);
    meas(sd[79], 1'b0, 8'h0);
    cnt(9'h1F8);
    flush();
    // streaming: the oldest frame makes way
    setc(mk(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 3'h0));
    for (int i = 0; i < 73; i++) meas(sd[i], 1'b0, 8'h0);
    cnt(9'h1F8);
    frame(1'b1, 1'b1, 1'b0, sd[1]);
    // collect off: nothing written, stored frames still readable
    apb(1'b1, srf_pkg::OFS_CTRL, 32'h6);
    meas(tm, 1'b1, 8'hF1);
    cnt(9'h1F1);
    frame(1'b1, 1'b1, 1'b0, sd[2]);
    flush();
    rd(srf_pkg::OFS_CTRL, 32'h6);
    cnt(9'h0);
    // time frame appended after the drained data, then empty headers
    setc(mk(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 3'h0));
    meas(sd[0], 1'b1, 8'h0);
    cnt(9'h4);
    frame(1'b1, 1'b0, 1'b0, sd[0]);
    tm = sd[0] ^ 24'h3C3C3C;
    rd(srf_pkg::OFS_DATA, 32'hA0);
    for (int i = 0; i < 3; i++) rd(srf_pkg::OFS_DATA, {24'h0, tm[8*i +: 8]});
    rd(srf_pkg::OFS_DATA, 32'h80);
    final_report();
  end
endmodule // sensor_result_fifo_tb
